// ===== src/vrelay_pkg.sv
// Package for the virtual relay zone controller: register map, field layout,
// reset values, state encodings and timing constants.
// Assumes a 200 MHz mclk and a software register port with one-cycle reads.
package vrelay_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SRCSEL   = 8'h04;
  localparam logic [7:0] OFS_SP1      = 8'h08;
  localparam logic [7:0] OFS_HYST1    = 8'h0c;
  localparam logic [7:0] OFS_SP2      = 8'h10;
  localparam logic [7:0] OFS_HYST2    = 8'h14;
  localparam logic [7:0] OFS_DELAY    = 8'h18;
  localparam logic [7:0] OFS_TOGGLE   = 8'h1c;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQSTAT  = 8'h24;
  localparam logic [7:0] OFS_IRQMASK  = 8'h28;

  // CTRL field positions
  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_TWO_BIT  = 2;
  localparam int CTRL_Z1_LSB   = 3;
  localparam int CTRL_Z2_LSB   = 5;
  localparam int CTRL_Z3_LSB   = 7;
  localparam int CTRL_NC_LSB   = 9;
  // SRCSEL field positions
  localparam int SRC_TANK_LSB  = 0;
  localparam int SRC_PARAM_LSB = 8;
  // Interrupt bit positions
  localparam int IRQ_ZONE      = 0;
  localparam int IRQ_ALARM     = 1;
  localparam int IRQ_CANCEL    = 2;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] SRCSEL_RST = 32'h0000_0000;
  localparam logic [31:0] SP_RST     = 32'h0000_0000;
  localparam logic [31:0] HYST_RST   = 32'h0000_0000;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] TOGGLE_RST = 16'h0032;

  // Timing: delay and toggle period count in 100 ms ticks
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 100_000_000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OUT_DISABLED = 2'h0,
    OUT_RELAY1   = 2'h1,
    OUT_RELAY2   = 2'h2
  } out_sel_t;

  typedef enum logic [1:0] {
    RS_NORMAL = 2'h0,
    RS_ALARM  = 2'h1,
    RS_TOGGLE = 2'h2
  } relay_state_t;

  typedef enum logic [1:0] {
    ZONE_1 = 2'h1,
    ZONE_2 = 2'h2,
    ZONE_3 = 2'h3
  } zone_t;

  // Delay tracker: Gray along idle -> wait
  typedef enum logic [1:0] {
    DLY_IDLE = 2'h0,
    DLY_WAIT = 2'h1
  } dly_state_t;

  typedef struct packed {
    logic [1:0]  outSel;
    logic        twoPoints;
    logic [1:0]  z1St;
    logic [1:0]  z2St;
    logic [1:0]  z3St;
    logic [1:0]  ncWiring;
    logic [3:0]  tankPos;
    logic [3:0]  tankParam;
    logic [31:0] sp1;
    logic [31:0] hyst1;
    logic [31:0] sp2;
    logic [31:0] hyst2;
    logic [15:0] delayTicks;
    logic [15:0] toggleTicks;
  } vr_cfg_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : vrelay_pkg

// ===== src/tick_gen.sv
// Tick prescaler: one-cycle pulse every TICK_CYC clock cycles.
// Assumes a free-running mclk; used as the timebase for delay and toggle.
`timescale 1ns/1ps
module tick_gen #(
  parameter int TICK_CYC = 20_000_000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Timebase
  output logic      tick
);
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("tick_gen: TICK_CYC must be at least 1");
  end

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + 32'h1;
    if (cnt_q >= 32'(TICK_CYC - 1)) begin
      cnt_d  = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // tick_gen

// ===== src/virtual_relay_zone_controller.sv
// Virtual relay zone controller: compares a selected tank measurement with
// one or two set points, tracks zones with hysteresis and drives a relay.
// Assumes the tank database answers srcValue/srcValid on mclk, no crossing.
// Function
// [RULE_01] Alarm state drives selected coil de-energized
// [RULE_02] Normally open contact open in Alarm
// [RULE_03] Normally closed contact closed in Alarm
// [RULE_04] Normal state keeps selected coil energized
// [RULE_05] Toggle alternates coil at configured period
// [RULE_06] Disabled output performs no relay switching
// [RULE_07] Output selection routes to relay one/two
// [RULE_08] Source chosen by tank position, parameter
// [RULE_09] Switch delay before entering Alarm state
// [RULE_10] One or two set points, two/three zones
// [RULE_11] Each zone holds its own target state
// [RULE_12] Each set point has own hysteresis
// [RULE_13] Crossing set point 1 applies zone 1
// [RULE_14] Zone 1 held until hysteresis cleared
// [RULE_15] Crossing set point 2 applies zone 3
// [RULE_16] Zone 3 held until hysteresis cleared
// [RULE_17] Point 1 bounds zones 1/2, 2 bounds 2/3
// [RULE_18] Leaving zone cancels pending alarm delay
`timescale 1ns/1ps
module virtual_relay_zone_controller
  import vrelay_pkg::*;
#(
  parameter int NUM_RELAYS = 2,
  parameter int TICK_CYC   = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // Tank database source
  output logic      [3:0]  srcTank,
  output logic      [3:0]  srcParam,
  input  wire logic [31:0] srcValue,
  input  wire logic        srcValid,
  // Relays
  output logic      [1:0]  relayCoil,
  output logic      [1:0]  relayContact,
  // Interrupt
  output logic             irq
);
  if (NUM_RELAYS < 1 || NUM_RELAYS > 2) begin : g_bad_relays
    $error("NUM_RELAYS must be 1 or 2");
  end

  // Signed compare on 33 bits so set point plus hysteresis cannot wrap for hysteresis up to 2^31
  function automatic logic signed [32:0] sx(input logic [31:0] v);
    return {v[31], v};
  endfunction

  function automatic logic signed [32:0] band(input logic [31:0] sp,
                                              input logic [31:0] h, input logic up);
    logic signed [32:0] hx;
    hx = $signed({1'b0, h});
    return up ? 33'(sx(sp) + hx) : 33'(sx(sp) - hx);
  endfunction

  reg_req_t req;
  assign req = '{addr: regAddr, wrData: regWrData, wr: regWr, rd: regRd};

  logic tick;
  tick_gen #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // Register file
  vr_cfg_t      cfg_q,  cfg_d;
  logic [2:0]   irqStat_q, irqStat_d;
  logic [2:0]   irqMask_q, irqMask_d;
  logic [31:0]  rdData_q,  rdData_d;
  logic [2:0]   events;
  logic [31:0]  statusWord;

  always_comb begin
    cfg_d     = cfg_q;
    irqMask_d = irqMask_q;
    // Set wins over a write-one-to-clear in the same cycle
    irqStat_d = irqStat_q;
    if (req.wr && req.addr == OFS_IRQSTAT) begin
      irqStat_d = irqStat_q & ~req.wrData[2:0];
    end
    irqStat_d = irqStat_d | events;
    if (req.wr) begin
      if (req.addr == OFS_CTRL) begin
        cfg_d.outSel    = req.wrData[CTRL_SEL_LSB +: 2];
        cfg_d.twoPoints = req.wrData[CTRL_TWO_BIT];
        cfg_d.z1St      = req.wrData[CTRL_Z1_LSB +: 2];
        cfg_d.z2St      = req.wrData[CTRL_Z2_LSB +: 2];
        cfg_d.z3St      = req.wrData[CTRL_Z3_LSB +: 2];
        cfg_d.ncWiring  = req.wrData[CTRL_NC_LSB +: 2];
      end else if (req.addr == OFS_SRCSEL) begin
        cfg_d.tankPos   = req.wrData[SRC_TANK_LSB +: 4];
        cfg_d.tankParam = req.wrData[SRC_PARAM_LSB +: 4];
      end else if (req.addr == OFS_SP1) begin
        cfg_d.sp1 = req.wrData;
      end else if (req.addr == OFS_HYST1) begin
        cfg_d.hyst1 = req.wrData;
      end else if (req.addr == OFS_SP2) begin
        cfg_d.sp2 = req.wrData;
      end else if (req.addr == OFS_HYST2) begin
        cfg_d.hyst2 = req.wrData;
      end else if (req.addr == OFS_DELAY) begin
        cfg_d.delayTicks = req.wrData[15:0];
      end else if (req.addr == OFS_TOGGLE) begin
        cfg_d.toggleTicks = req.wrData[15:0];
      end else if (req.addr == OFS_IRQMASK) begin
        irqMask_d = req.wrData[2:0];
      end
    end
    rdData_d = 32'h0;
    if (req.rd) begin
      if (req.addr == OFS_CTRL) begin
        rdData_d = {21'h0, cfg_q.ncWiring, cfg_q.z3St, cfg_q.z2St, cfg_q.z1St,
                    cfg_q.twoPoints, cfg_q.outSel};
      end else if (req.addr == OFS_SRCSEL) begin
        rdData_d = {20'h0, cfg_q.tankParam, 4'h0, cfg_q.tankPos};
      end else if (req.addr == OFS_SP1) begin
        rdData_d = cfg_q.sp1;
      end else if (req.addr == OFS_HYST1) begin
        rdData_d = cfg_q.hyst1;
      end else if (req.addr == OFS_SP2) begin
        rdData_d = cfg_q.sp2;
      end else if (req.addr == OFS_HYST2) begin
        rdData_d = cfg_q.hyst2;
      end else if (req.addr == OFS_DELAY) begin
        rdData_d = {16'h0, cfg_q.delayTicks};
      end else if (req.addr == OFS_TOGGLE) begin
        rdData_d = {16'h0, cfg_q.toggleTicks};
      end else if (req.addr == OFS_STATUS) begin
        rdData_d = statusWord;
      end else if (req.addr == OFS_IRQSTAT) begin
        rdData_d = {29'h0, irqStat_q};
      end else if (req.addr == OFS_IRQMASK) begin
        rdData_d = {29'h0, irqMask_q};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= '{outSel: CTRL_RST[1:0], twoPoints: CTRL_RST[2], z1St: CTRL_RST[4:3],
                 z2St: CTRL_RST[6:5], z3St: CTRL_RST[8:7], ncWiring: CTRL_RST[10:9],
                 tankPos: SRCSEL_RST[3:0], tankParam: SRCSEL_RST[11:8],
                 sp1: SP_RST, hyst1: HYST_RST, sp2: SP_RST, hyst2: HYST_RST,
                 delayTicks: DELAY_RST, toggleTicks: TOGGLE_RST};
      irqStat_q <= 3'h0;
      irqMask_q <= 3'h0;
      rdData_q  <= 32'h0;
    end else begin
      cfg_q     <= cfg_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      rdData_q  <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign irq       = |(irqStat_q & irqMask_q);
  // [RULE_08] Source selection
  assign srcTank   = cfg_q.tankPos;
  assign srcParam  = cfg_q.tankParam;

  // Zone tracking, alarm delay and toggle phase
  zone_t        zone_q, zone_d;
  dly_state_t   dly_q, dly_d;
  relay_state_t applied_q, applied_d;
  relay_state_t target;
  logic [15:0]  dlyCnt_q, dlyCnt_d;
  logic [15:0]  togCnt_q, togCnt_d;
  logic         phase_q, phase_d;
  logic [1:0]   coil_q, coil_d;
  logic [1:0]   contact_q, contact_d;
  logic         vrCoil;
  logic         below1, clear1, above2, clear2;

  // [RULE_12] Per set point hysteresis bands
  assign below1 = $signed(sx(srcValue)) < $signed(sx(cfg_q.sp1));
  assign clear1 = $signed(sx(srcValue)) >= band(cfg_q.sp1, cfg_q.hyst1, 1'b1);
  assign above2 = $signed(sx(srcValue)) > $signed(sx(cfg_q.sp2));
  assign clear2 = $signed(sx(srcValue)) <= band(cfg_q.sp2, cfg_q.hyst2, 1'b0);

  // [RULE_11] Zone target state
  always_comb begin
    case (zone_q)
      ZONE_1:  target = relay_state_t'(cfg_q.z1St);
      ZONE_3:  target = relay_state_t'(cfg_q.z3St);
      default: target = relay_state_t'(cfg_q.z2St);
    endcase
  end

  always_comb begin
    zone_d    = zone_q;
    dly_d     = dly_q;
    dlyCnt_d  = dlyCnt_q;
    applied_d = applied_q;
    events    = 3'h0;
    // [RULE_17] Point 1 sits below point 2 on an ascending scale
    if (srcValid) begin
      case (zone_q)
        // [RULE_13] Crossing into zone 1
        ZONE_2: begin
          if (below1) begin
            zone_d = ZONE_1;
          // [RULE_10] Zone 3 exists only with two points
          // [RULE_15] Crossing into zone 3
          end else if (cfg_q.twoPoints && above2) begin
            zone_d = ZONE_3;
          end
        end
        // [RULE_14] Hold zone 1 until band cleared
        ZONE_1: begin
          if (clear1) zone_d = ZONE_2;
        end
        // [RULE_16] Hold zone 3 until band cleared
        default: begin
          if (clear2 || !cfg_q.twoPoints) zone_d = ZONE_2;
        end
      endcase
    end
    events[IRQ_ZONE] = (zone_d != zone_q);
    case (dly_q)
      DLY_IDLE: begin
        dlyCnt_d = 16'h0;
        if (target != RS_ALARM) begin
          applied_d = target;
        end else if (applied_q != RS_ALARM) begin
          // [RULE_09] Zero delay switches at once
          if (cfg_q.delayTicks == 16'h0) begin
            applied_d = RS_ALARM;
          end else begin
            dly_d = DLY_WAIT;
          end
        end
      end
      default: begin
        // [RULE_18] Source left the zone: cancel and rearm
        if (target != RS_ALARM) begin
          dly_d     = DLY_IDLE;
          dlyCnt_d  = 16'h0;
          applied_d = target;
          events[IRQ_CANCEL] = 1'b1;
        end else if (tick) begin
          dlyCnt_d = dlyCnt_q + 16'h1;
          // [RULE_09] Alarm only after the full delay
          if (dlyCnt_d >= cfg_q.delayTicks) begin
            dly_d     = DLY_IDLE;
            applied_d = RS_ALARM;
          end
        end
      end
    endcase
    events[IRQ_ALARM] = (applied_d == RS_ALARM) && (applied_q != RS_ALARM);
  end

  // [RULE_05] Toggle phase flips once per period
  always_comb begin
    togCnt_d = 16'h0;
    phase_d  = 1'b1;
    if (applied_q == RS_TOGGLE) begin
      togCnt_d = togCnt_q;
      phase_d  = phase_q;
      if (tick) begin
        togCnt_d = togCnt_q + 16'h1;
        if (togCnt_d >= cfg_q.toggleTicks) begin
          togCnt_d = 16'h0;
          phase_d  = !phase_q;
        end
      end
    end
  end

  // [RULE_01] [RULE_04] Coil level per resolved state
  always_comb begin
    case (applied_q)
      RS_NORMAL: vrCoil = 1'b1;
      RS_TOGGLE: vrCoil = phase_q;
      default:   vrCoil = 1'b0;
    endcase
  end

  always_comb begin
    coil_d = 2'h0;
    // [RULE_07] Route to the fitted relay; [RULE_06] none when disabled
    if (cfg_q.outSel == OUT_RELAY1) begin
      coil_d[0] = vrCoil;
    end else if (cfg_q.outSel == OUT_RELAY2 && NUM_RELAYS == 2) begin
      coil_d[1] = vrCoil;
    end
    // [RULE_02] [RULE_03] Contact follows wiring when de-energized
    contact_d = coil_d ^ cfg_q.ncWiring;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      zone_q    <= ZONE_2;
      dly_q     <= DLY_IDLE;
      dlyCnt_q  <= 16'h0;
      applied_q <= RS_NORMAL;
      togCnt_q  <= 16'h0;
      phase_q   <= 1'b1;
      coil_q    <= 2'h0;
      contact_q <= 2'h0;
    end else begin
      zone_q    <= zone_d;
      dly_q     <= dly_d;
      dlyCnt_q  <= dlyCnt_d;
      applied_q <= applied_d;
      togCnt_q  <= togCnt_d;
      phase_q   <= phase_d;
      coil_q    <= coil_d;
      contact_q <= contact_d;
    end
  end

  assign relayCoil    = coil_q;
  assign relayContact = contact_q;
  assign statusWord   = {23'h0, (dly_q == DLY_WAIT), contact_q, coil_q, applied_q, zone_q};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_pending;
    dly_q == DLY_WAIT && target == RS_ALARM;
  endsequence
  sequence s_leave;
    target != RS_ALARM;
  endsequence

  a_alarm_coil_off: assert property ( // [RULE_01]
    (applied_q == RS_ALARM && cfg_q.outSel == OUT_RELAY1) |=> !relayCoil[0])
    else $error("coil energized in alarm");
  a_normal_coil_on: assert property ( // [RULE_04]
    (applied_q == RS_NORMAL && cfg_q.outSel == OUT_RELAY1) |=> relayCoil[0])
    else $error("coil not energized in normal");
  a_no_contact_open: assert property ( // [RULE_02]
    (applied_q == RS_ALARM && cfg_q.outSel == OUT_RELAY1 && !cfg_q.ncWiring[0])
      |=> !relayContact[0])
    else $error("open-wired contact not open in alarm");
  a_nc_contact_closed: assert property ( // [RULE_03]
    (applied_q == RS_ALARM && cfg_q.outSel == OUT_RELAY1 && cfg_q.ncWiring[0])
      |=> relayContact[0])
    else $error("closed-wired contact not closed in alarm");
  a_disabled_quiet: assert property ( // [RULE_06]
    cfg_q.outSel == OUT_DISABLED |=> relayCoil == 2'h0)
    else $error("coil driven while disabled");
  a_zone1_entry: assert property ( // [RULE_13]
    (srcValid && zone_q == ZONE_2 && below1) |=> zone_q == ZONE_1)
    else $error("zone 1 not entered");
  a_hyst1_hold: assert property ( // [RULE_14]
    (zone_q == ZONE_1 && !(srcValid && clear1)) |=> zone_q == ZONE_1)
    else $error("zone 1 left inside band");
  a_hyst2_hold: assert property ( // [RULE_16]
    (zone_q == ZONE_3 && cfg_q.twoPoints && !(srcValid && clear2)) |=> zone_q == ZONE_3)
    else $error("zone 3 left inside band");
  a_delay_respect: assert property ( // [RULE_09]
    (applied_q != RS_ALARM && cfg_q.delayTicks != 16'h0 && $stable(cfg_q.delayTicks)
      && !(dly_q == DLY_WAIT && tick && dlyCnt_q + 16'h1 >= cfg_q.delayTicks))
      |=> applied_q != RS_ALARM)
    else $error("alarm entered before delay elapsed");
  a_delay_cancel: assert property ( // [RULE_18]
    s_pending ##1 s_leave |=> dly_q == DLY_IDLE && dlyCnt_q == 16'h0)
    else $error("pending alarm not cancelled");
endmodule // virtual_relay_zone_controller

// ===== test/relay_bank_model.sv
// Relay bank model: two coils switching external alarm contacts.
// Assumes coil levels from the controller; wiring kind is set by the bench.
`timescale 1ns/1ps
module relay_bank_model (
  // Clock
  input  wire logic       mclk,
  // Coil drive and wiring kind
  input  wire logic [1:0] coil,
  input  wire logic [1:0] ncWired,
  // Contacts and switching count
  output logic      [1:0] contactSeen,
  output int              flips
);
  logic [1:0] lastCoil;
  assign contactSeen = coil ^ ncWired;
  initial flips = 0;
  initial lastCoil = 2'h0;
  // Counts every coil change, so a stuck toggle shows as zero
  always @(posedge mclk) begin
    if (coil !== lastCoil) flips <= flips + 1;
    lastCoil <= coil;
  end
endmodule // relay_bank_model

// ===== test/tb_virtual_relay_zone_controller.sv
// Testbench for the virtual relay zone controller with an integer zone model.
// Assumes a 200 MHz mclk and TICK_CYC shortened to 4 cycles per tick.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((e) !== (g)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_virtual_relay_zone_controller;
  import vrelay_pkg::*;
  localparam int TCYC = 4;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdData;
  logic [3:0]  srcTank;
  logic [3:0]  srcParam;
  logic [31:0] srcValue = 32'h0;
  logic        srcValid = 1'b0;
  logic [1:0]  relayCoil;
  logic [1:0]  relayContact;
  logic        irq;
  logic [1:0]  ncBits = 2'h0;
  logic [1:0]  expCoil;
  logic [1:0]  modelContact;
  logic [31:0] d;
  int          flips;
  int mismatches = 0, nTests = 0, cycleCount = 0, seed, zone = 2, sel, two, st, t, f0;
  int sp1 = 100, h1 = 10, sp2 = 200, h2 = 20;
  int zst [1:3];
  int dir [$] = '{150, 99, 105, 110, 201, 185, 180, 99, 250};
  always #2.5 mclk = ~mclk;
  virtual_relay_zone_controller #(.NUM_RELAYS(2), .TICK_CYC(TCYC)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcTank(srcTank),
    .srcParam(srcParam), .srcValue(srcValue), .srcValid(srcValid),
    .relayCoil(relayCoil), .relayContact(relayContact), .irq(irq));
  relay_bank_model i_relay (.mclk(mclk), .coil(relayCoil), .ncWired(ncBits),
    .contactSeen(modelContact), .flips(flips));
  function automatic int nz(int z, int v);
    if (z == 2 && v < sp1) return 1;
    if (z == 1 && v >= sp1 + h1) return 2;
    if (two != 0 && z == 2 && v > sp2) return 3;
    if (z == 3 && (v <= sp2 - h2 || two == 0)) return 2;
    return z;
  endfunction
  function automatic logic [31:0] ctl(int o, int w, int a, int b, int c, int n);
    return 32'((o << CTRL_SEL_LSB) | (w << CTRL_TWO_BIT) | (a << CTRL_Z1_LSB) |
      (b << CTRL_Z2_LSB) | (c << CTRL_Z3_LSB) | (n << CTRL_NC_LSB));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge mclk) begin
      regWr <= 1'b1; regAddr <= a; regWrData <= dat;
    end
    @(posedge mclk) regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge mclk) begin
      regRd <= 1'b1; regAddr <= a;
    end
    @(posedge mclk) regRd <= 1'b0;
    #1 q = regRdData;
  endtask
  task automatic cfg(int o, int w, int n);
    sel = o; two = w; ncBits = 2'(n);
    wr(OFS_CTRL, ctl(o, w, zst[1], zst[2], zst[3], n));
  endtask
  // Model tracks the zone only while the source is valid
  task automatic setv(input int v, input int n);
    @(posedge mclk) srcValue <= 32'(v);
    repeat (n) @(posedge mclk);
    if (srcValid === 1'b1) repeat (3) zone = nz(zone, v);
  endtask
  task automatic chkState;
    rd(OFS_STATUS, d);
    `CHK("zone", 2'(zone), d[1:0])
    st = zst[zone];
    expCoil = (sel == 1) ? {1'b0, st == 0} : (sel == 2) ? {st == 0, 1'b0} : 2'h0;
    `CHK("model contact", modelContact, relayContact)
    if (st != int'(RS_TOGGLE)) begin
      `CHK("coil", expCoil, relayCoil)
      `CHK("contact", expCoil ^ ncBits, relayContact)
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 42;
    zst = '{1, 0, 2};
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_CTRL, d);
    `CHK("ctrl reset", CTRL_RST, d)
    rd(OFS_TOGGLE, d);
    `CHK("toggle reset", 32'(TOGGLE_RST), d)
    rd(8'h30, d);
    `CHK("unmapped", 32'h0, d)
    rd(OFS_STATUS, d);
    `CHK("status reset", 32'h2, d)
    t = $random(seed) & 32'h0f0f;
    wr(OFS_SRCSEL, 32'(t));
    // Registers take the write on this edge; look once they have settled
    #1;
    `CHK("source select", {4'(t >> 8), 4'(t)}, {srcParam, srcTank})
    wr(OFS_SP1, 32'(sp1));
    wr(OFS_HYST1, 32'(h1));
    wr(OFS_SP2, 32'(sp2));
    wr(OFS_HYST2, 32'(h2));
    wr(OFS_TOGGLE, 32'h2);
    srcValid <= 1'b1;
    for (int k = 1; k <= 2; k++) begin
      cfg(k, 1, k == 2 ? 2 : 0);
      foreach (dir[i]) begin
        setv(dir[i], 4);
        chkState();
      end
      repeat (30) begin
        setv(50 + {$random(seed)} % 200, 4);
        chkState();
      end
    end
    setv(250, 4);
    f0 = flips;
    repeat (80) @(posedge mclk);
    `CHK("toggle flips", 1'b1, (flips - f0 >= 9 && flips - f0 <= 11))
    wr(OFS_DELAY, 32'h3);
    setv(150, 4);
    wr(OFS_IRQMASK, 32'h2);
    wr(OFS_IRQSTAT, 32'h7);
    setv(99, 5);
    `CHK("coil pending", 2'h2, relayCoil)
    `CHK("irq pending", 1'b0, irq)
    repeat (20) @(posedge mclk);
    `CHK("coil alarm", 2'h0, relayCoil)
    `CHK("contact nc", 2'h2, relayContact)
    `CHK("irq alarm", 1'b1, irq)
    wr(OFS_IRQSTAT, 32'h2);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    setv(150, 4);
    wr(OFS_IRQSTAT, 32'h7);
    setv(99, 5);
    setv(150, 4);
    repeat (20) @(posedge mclk);
    `CHK("coil cancel", 2'h2, relayCoil)
    rd(OFS_IRQSTAT, d);
    `CHK("cancel flag", 1'b1, d[IRQ_CANCEL])
    cfg(0, 1, 3);
    repeat (3) @(posedge mclk);
    `CHK("disabled coil", 2'h0, relayCoil)
    `CHK("disabled contact", 2'h3, relayContact)
    cfg(1, 0, 3);
    setv(300, 4);
    chkState();
    @(posedge mclk) srcValid <= 1'b0;
    setv(50, 4);
    chkState();
    tally_and_finish();
  end
endmodule // tb_virtual_relay_zone_controller
